// ### rtl/step_cfg_pkg.sv
// Package with the register map, field layout and source codes of step 12.
package step_cfg_pkg;
   // Register offset (byte address on the bus) and width.
   localparam logic [7:0] STEP12_CFG_OFFSET = 8'h9c;
   localparam int CFG_WIDTH = 16;
   localparam logic [15:0] STEP12_CFG_RESET = 16'h000c;
   // Field positions.
   localparam int INCLUDE_BIT = 15;
   localparam int GAIN_HI = 14;
   localparam int GAIN_LO = 13;
   localparam int NEG_BIT = 4;
   localparam int POS_HI = 3;
   localparam int POS_LO = 0;
   // Mask of the writable bits; bits 12 to 5 are reserved.
   localparam logic [15:0] WRITABLE_MASK = 16'he01f;
   // Decoded gain factors.
   typedef enum logic [2:0] {
      GAIN_X1 = 3'b001,
      GAIN_X2 = 3'b010,
      GAIN_X4 = 3'b100
   } gain_t;
   // Negative source selection seen by the converter front end.
   typedef enum logic [1:0] {
      NEG_ANALOG_GROUND = 2'b00,
      NEG_EXTERNAL_SEVEN = 2'b01,
      NEG_AUTOMATIC = 2'b10
   } neg_source_t;
   // Positive-select codes with a special meaning.
   localparam logic [3:0] POS_FIRST_INTERNAL = 4'h8;
   localparam logic [3:0] POS_TEMP_SENSOR = 4'h8;
   localparam logic [3:0] POS_GROUND_SHORT = 4'h9;
   localparam logic [3:0] POS_IO_SUPPLY_DIV4 = 4'hc;
   localparam logic [3:0] POS_DIG_REG_DIV103 = 4'hf;
endpackage : step_cfg_pkg

// ### rtl/step_source_decode.sv
// Decoder from the stored step fields to the sequencer's source controls.
`timescale 1ns/1ns
module step_source_decode (
   // Stored fields
   input wire logic [1:0] i_gain_code,
   input wire logic i_neg_code,
   input wire logic [3:0] i_pos_code,
   // Decoded controls
   output step_cfg_pkg::gain_t o_gain,
   output step_cfg_pkg::neg_source_t o_neg_source,
   output logic o_pos_external,
   output logic [2:0] o_pos_external_index,
   output logic o_temp_sensor,
   output logic o_ground_short,
   output logic o_io_supply_div4,
   output logic o_dig_reg_div103
);
   always_comb begin
      unique case (i_gain_code)
         2'b00: o_gain = step_cfg_pkg::GAIN_X1;
         2'b01: o_gain = step_cfg_pkg::GAIN_X2;
         2'b10, 2'b11: o_gain = step_cfg_pkg::GAIN_X4;
      endcase
   end

   always_comb begin
      if (i_pos_code >= step_cfg_pkg::POS_FIRST_INTERNAL) begin
         o_neg_source = step_cfg_pkg::NEG_AUTOMATIC;
      end else if (i_neg_code) begin
         o_neg_source = step_cfg_pkg::NEG_EXTERNAL_SEVEN;
      end else begin
         o_neg_source = step_cfg_pkg::NEG_ANALOG_GROUND;
      end
   end

   assign o_pos_external = ~i_pos_code[3];
   assign o_pos_external_index = i_pos_code[2:0];
   // Codes 1010b, 1011b, 1101b and 1110b drive none of the named strobes.
   assign o_temp_sensor = (i_pos_code == step_cfg_pkg::POS_TEMP_SENSOR);
   assign o_ground_short = (i_pos_code == step_cfg_pkg::POS_GROUND_SHORT);
   assign o_io_supply_div4 =
      (i_pos_code == step_cfg_pkg::POS_IO_SUPPLY_DIV4);
   assign o_dig_reg_div103 =
      (i_pos_code == step_cfg_pkg::POS_DIG_REG_DIV103);
endmodule : step_source_decode

// ### rtl/sequence_step12_config.sv
// Step 12 configuration register of the auxiliary converter sequencer.
// Notes on behaviour
// - Step included only while bit 15 set
// - Gain code 00,01,1x gives 1,2,4
// - Bit 4 picks ground or input seven
// - Codes 0-7 pick external inputs 0-7
// - Codes from 1000b choose negative automatically
// - 1000b temperature sensor, 1001b ground short
// - 1100b io supply/4, 1111b regulator/103
// - Address 9Ch, resets to 000Ch
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ns
module sequence_step12_config (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Avalon-MM slave
   input wire logic [7:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   output logic [1:0] o_response,
   // Sequencer controls
   output logic o_step_include_flag,
   output step_cfg_pkg::gain_t o_step_gain,
   output step_cfg_pkg::neg_source_t o_step_neg_source,
   output logic o_step_pos_external,
   output logic [2:0] o_step_pos_external_index,
   output logic o_step_temp_sensor,
   output logic o_step_ground_short,
   output logic o_step_io_supply_div4,
   output logic o_step_dig_reg_div103
);
   logic [15:0] cfg_reg;
   logic [15:0] cfg_next;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [1:0] resp_reg;
   logic hit;
   logic [15:0] lane_mask;

   // Every access waits exactly one cycle so read data come from a flop.
   assign o_waitrequest = (i_read | i_write) & ~ack_reg;
   assign o_readdata = rdata_reg;
   assign o_response = resp_reg;
   assign hit = (i_address == step_cfg_pkg::STEP12_CFG_OFFSET);
   assign lane_mask = {{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};

   always_comb begin
      cfg_next = cfg_reg;
      if (i_write && hit && !ack_reg) begin
         cfg_next = ((i_writedata[15:0] & lane_mask) |
                     (cfg_reg & ~lane_mask))
                    & step_cfg_pkg::WRITABLE_MASK;
      end
   end

   always_comb begin
      rdata_next = 32'h0000_0000;
      if (hit) begin
         rdata_next = {16'h0000, cfg_reg & step_cfg_pkg::WRITABLE_MASK};
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         cfg_reg <= step_cfg_pkg::STEP12_CFG_RESET;
      end else begin
         cfg_reg <= cfg_next;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         resp_reg <= 2'b00;
      end else begin
         ack_reg <= (i_read | i_write) & ~ack_reg;
         if ((i_read | i_write) && !ack_reg) begin
            rdata_reg <= i_read ? rdata_next : 32'h0000_0000;
            // Unmapped addresses answer with the slave-error code.
            resp_reg <= hit ? 2'b00 : 2'b10;
         end
      end
   end

   assign o_step_include_flag = cfg_reg[step_cfg_pkg::INCLUDE_BIT];

   step_source_decode u_decode (
      .i_gain_code(cfg_reg[step_cfg_pkg::GAIN_HI:step_cfg_pkg::GAIN_LO]),
      .i_neg_code(cfg_reg[step_cfg_pkg::NEG_BIT]),
      .i_pos_code(cfg_reg[step_cfg_pkg::POS_HI:step_cfg_pkg::POS_LO]),
      .o_gain(o_step_gain),
      .o_neg_source(o_step_neg_source),
      .o_pos_external(o_step_pos_external),
      .o_pos_external_index(o_step_pos_external_index),
      .o_temp_sensor(o_step_temp_sensor),
      .o_ground_short(o_step_ground_short),
      .o_io_supply_div4(o_step_io_supply_div4),
      .o_dig_reg_div103(o_step_dig_reg_div103)
   );

   property p_reset_value;
      @(posedge i_clk) !i_reset_n |=>
         cfg_reg == step_cfg_pkg::STEP12_CFG_RESET;
   endproperty
   AST_RESET_VALUE: assert property (p_reset_value)
      else $error("Register did not reset to its documented value.");

   sequence s_full_write;
      i_write && hit && !ack_reg && (i_byteenable[1:0] == 2'b11);
   endsequence
   AST_WRITE_STORES: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      s_full_write |=> cfg_reg == ($past(i_writedata[15:0]) & 16'he01f))
      else $error("Write did not store the writable bits.");

   // The upper half and the reserved middle bits never carry data.
   AST_RESERVED_ZERO: assert property (@(posedge i_clk)
      disable iff (!i_reset_n)
      cfg_reg[12:5] == 8'h00 && rdata_reg[31:16] == 16'h0000
      && rdata_reg[12:5] == 8'h00)
      else $error("Reserved bits are not zero.");

   AST_INCLUDE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_step_include_flag == cfg_reg[15])
      else $error("Step include does not follow bit 15.");

   AST_GAIN_FOUR: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      cfg_reg[14] |-> o_step_gain == step_cfg_pkg::GAIN_X4)
      else $error("Gain codes 10b and 11b must give gain four.");

   AST_NEG_SELECT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !cfg_reg[3] |-> o_step_neg_source ==
      (cfg_reg[4] ? step_cfg_pkg::NEG_EXTERNAL_SEVEN
                  : step_cfg_pkg::NEG_ANALOG_GROUND))
      else $error("Negative select does not follow bit 4.");

   AST_NEG_AUTO: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      cfg_reg[3] |-> o_step_neg_source == step_cfg_pkg::NEG_AUTOMATIC
      && !o_step_pos_external)
      else $error("Internal source did not select negative automatically.");

   AST_POS_EXT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !cfg_reg[3] |-> o_step_pos_external
      && o_step_pos_external_index == cfg_reg[2:0])
      else $error("External positive input index is wrong.");

   AST_INTERNAL: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (o_step_temp_sensor == (cfg_reg[3:0] == 4'h8))
      && (o_step_ground_short == (cfg_reg[3:0] == 4'h9)))
      else $error("Temperature or ground-short strobe is wrong.");

   AST_SUPPLY: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (o_step_io_supply_div4 == (cfg_reg[3:0] == 4'hc))
      && (o_step_dig_reg_div103 == (cfg_reg[3:0] == 4'hf)))
      else $error("Supply monitor strobe is wrong.");

   AST_ONE_WAIT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ((i_read | i_write) && !ack_reg) |=> !o_waitrequest)
      else $error("Slave did not answer after one wait cycle.");
endmodule : sequence_step12_config

// ### tb/tb_sequence_step12_config.sv
// Self-checking bench for the step 12 configuration register.
`timescale 1ns/1ns
module tb_sequence_step12_config;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic [7:0] i_address = 8'h00;
   logic i_read = 1'b0;
   logic i_write = 1'b0;
   logic [31:0] i_writedata = 32'h0000_0000;
   logic [3:0] i_byteenable = 4'h0;
   logic [31:0] o_readdata;
   logic o_waitrequest;
   logic [1:0] o_response;
   logic o_step_include_flag;
   step_cfg_pkg::gain_t o_step_gain;
   step_cfg_pkg::neg_source_t o_step_neg_source;
   logic o_step_pos_external;
   logic [2:0] o_step_pos_external_index;
   logic o_temp, o_gnd, o_io, o_dig;
   int error_cnt = 0;
   int check_count = 0;
   logic [31:0] rd;
   logic [1:0] rsp;
   // Each row holds the written value above the expected read value.
   logic [31:0] rows [8] = '{32'h8000_8000, 32'h2001_2001, 32'h4012_4012,
      32'h6017_6017, 32'hffff_e01f, 32'h1fe8_0008, 32'h0019_0019,
      32'h001c_001c};
   wire [13:0] seen = {o_step_include_flag, o_step_gain, o_step_neg_source,
      o_step_pos_external, o_step_pos_external_index, o_temp, o_gnd, o_io,
      o_dig};

   sequence_step12_config i_sequence_step12_config (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_address(i_address),
      .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
      .i_byteenable(i_byteenable), .o_readdata(o_readdata),
      .o_waitrequest(o_waitrequest), .o_response(o_response),
      .o_step_include_flag(o_step_include_flag), .o_step_gain(o_step_gain),
      .o_step_neg_source(o_step_neg_source),
      .o_step_pos_external(o_step_pos_external),
      .o_step_pos_external_index(o_step_pos_external_index),
      .o_step_temp_sensor(o_temp), .o_step_ground_short(o_gnd),
      .o_step_io_supply_div4(o_io), .o_step_dig_reg_div103(o_dig));

   initial forever #50 i_clk = ~i_clk;

   // Expected sequencer controls for a stored register value.
   function automatic logic [13:0] dec(input logic [15:0] r);
      logic [2:0] g;
      logic [1:0] n;
      g = r[14] ? 3'h4 : (r[13] ? 3'h2 : 3'h1);
      n = r[3] ? 2'h2 : {1'b0, r[4]};
      return {r[15], g, n, !r[3], r[2:0], r[3:0] == 4'h8, r[3:0] == 4'h9,
         r[3:0] == 4'hc, r[3:0] == 4'hf};
   endfunction : dec

   task automatic check(input string name, input logic [31:0] s,
         input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, e, s);
      end
   endtask : check

   task automatic test_done;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done

   // One bus transfer; an idle edge always precedes the request.
   task automatic bus(input logic wr, input logic [7:0] a,
         input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge i_clk);
      i_address <= a;
      i_write <= wr;
      i_read <= !wr;
      i_writedata <= d;
      i_byteenable <= be;
      do begin
         @(negedge i_clk);
         n++;
      end while (o_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) error_cnt++;
      @(posedge i_clk);
      rd = o_readdata;
      rsp = o_response;
      i_read <= 1'b0;
      i_write <= 1'b0;
   endtask : bus

   initial begin
      repeat (3) @(posedge i_clk);
      i_reset_n <= 1'b1;
      @(negedge i_clk);
      check("reset decode", seen, dec(16'h000c));
      bus(1'b0, 8'h9c, 32'h0000_0000, 4'hf);
      check("reset value", rd, 32'h0000_000c);
      check("response", rsp, 2'h0);
      foreach (rows[k]) begin
         bus(1'b1, 8'h9c, {16'h0000, rows[k][31:16]}, 4'h3);
         check("decode", seen, dec(rows[k][15:0]));
         bus(1'b0, 8'h9c, 32'h0000_0000, 4'hf);
         check("readback", rd, {16'h0000, rows[k][15:0]});
      end
      for (int c = 0; c < 16; c++) begin
         bus(1'b1, 8'h9c, 32'h0000_0010 | c, 4'hf);
         check("source", seen, dec(16'h0010 | 16'(c)));
      end
      bus(1'b1, 8'h9d, 32'h0000_0000, 4'hf);
      bus(1'b0, 8'h9d, 32'h0000_0000, 4'hf);
      check("unmapped data", rd, 32'h0000_0000);
      check("unmapped resp", rsp, 2'h2);
      bus(1'b1, 8'h9c, 32'h0000_8000, 4'h2);
      bus(1'b0, 8'h9c, 32'h0000_0000, 4'hf);
      check("lane write", rd, 32'h0000_801f);
      @(posedge i_clk);
      i_reset_n <= 1'b0;
      @(posedge i_clk);
      i_reset_n <= 1'b1;
      bus(1'b0, 8'h9c, 32'h0000_0000, 4'hf);
      check("second reset", rd, 32'h0000_000c);
      test_done;
   end

   // A run still going after 2000 clock cycles ends through the same closing task.
   initial begin
      repeat (2000) @(posedge i_clk);
      error_cnt++;
      test_done;
   end
endmodule : tb_sequence_step12_config
